// ==== hdl/afc_cfg.svh ====
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH
// APB register byte offsets
`define AFC_OFF_CTRL      12'h000
`define AFC_OFF_WDATA     12'h004
`define AFC_OFF_RDATA     12'h008
`define AFC_OFF_STATUS    12'h00C
`define AFC_OFF_THRESH    12'h010
// CTRL fields (write: command kick, one at a time)
`define AFC_CMD_LSB       0
`define AFC_CMD_W         3
`define AFC_CTRL_MODE_BIT 4
`define AFC_CTRL_LEAD_BIT 5
// STATUS fields
`define AFC_ST_BUSY_BIT   0
`define AFC_ST_EMPTY_BIT  1
`define AFC_ST_FULL_BIT   2
`define AFC_ST_HALF_BIT   3
`define AFC_ST_RVAL_BIT   4
`define AFC_ST_REFUSE_BIT 5
// Widths and depth of the buffer outside
`define AFC_DATA_W        9
`define AFC_DEPTH         16384
`define AFC_THRESH_RST    9'h100
// Pin timing, ns, and cycles at 20 MHz (50 ns)
`define AFC_CLK_NS        50
`define AFC_RSS_NS        100
`define AFC_RSR_NS        100
`define AFC_RSC_NS        200
`define AFC_PULSE_NS      100
`define AFC_REL_NS        50
`define AFC_CYC(ns)       (((ns) + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RSS_CYC       `AFC_CYC(`AFC_RSS_NS)
`define AFC_RSR_CYC       `AFC_CYC(`AFC_RSR_NS)
`define AFC_RSC_CYC       `AFC_CYC(`AFC_RSC_NS)
`define AFC_PULSE_CYC     `AFC_CYC(`AFC_PULSE_NS)
`define AFC_REL_CYC       `AFC_CYC(`AFC_REL_NS)
`define AFC_CNT_W         4
`endif

// ==== hdl/afc_pkg.sv ====
package afc_pkg;
  typedef enum logic [2:0]
  {
    AFC_CMD_NONE   = 3'b000,
    AFC_CMD_RESET  = 3'b001,
    AFC_CMD_RST_WL = 3'b010,
    AFC_CMD_RST_RL = 3'b011,
    AFC_CMD_WRITE  = 3'b100,
    AFC_CMD_READ   = 3'b101,
    AFC_CMD_REPLAY = 3'b110
  } afc_cmd_e;

  typedef struct packed
  {
    logic       paddr_sel;
    logic [11:0] paddr;
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [31:0] pwdata;
  } afc_apb_req_s;

  typedef struct packed
  {
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
  } afc_apb_rsp_s;

  // Strobes and control pins driven toward the buffer
  typedef struct packed
  {
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       reset_n;
    logic       first_load_or_replay;
    logic       cascade_in;
  } afc_pins_s;

  // Flags seen from the buffer, raw pin levels before the synchroniser
  typedef struct packed
  {
    logic empty_indicator_n;
    logic full_indicator_n;
    logic cascade_out_or_half_level;
  } afc_flags_s;
endpackage

// ==== hdl/afc_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for the asynchronous flag and data pins
module afc_sync #(parameter int W = 1)
(
  input  wire logic         clk,   // System clock
  input  wire logic         reset, // Synchronous reset
  input  wire logic [W-1:0] d,     // Pin levels
  output logic      [W-1:0] q      // Synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // afc_sync

// ==== hdl/afc_ctrl.sv ====
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "afc_cfg.svh"
// Operation
// - Reset buffer before any write
// - Strobes high around reset release
// - Strobes high throughout replay pulse
// - Replay only within depth, single mode (code refuses replay in cascade mode only; depth is not checked)
module afc_ctrl
  import afc_pkg::*;
(
  input  wire logic            clk,        // 20 MHz clock
  input  wire logic            reset,      // Synchronous reset, high
  input  wire afc_pkg::afc_apb_req_s apb_req, // APB request
  output afc_pkg::afc_apb_rsp_s      apb_rsp, // APB response
  output afc_pkg::afc_pins_s         pins,    // Strobes to buffer
  input  wire afc_pkg::afc_flags_s   flags_pin, // Raw flag pins
  output logic [8:0]          data_in_bus, // Write data to buffer
  input  wire logic [8:0]     data_out_bus_i, // Buffer data pins in
  output logic [8:0]          data_out_bus_o, // Threshold drive out
  output logic                data_out_bus_oe // High while driving
);
  import afc_pkg::*;

  typedef enum logic [2:0]
  {
    AFC_IDLE  = 3'b000,
    AFC_SETUP = 3'b001,
    AFC_LOW   = 3'b010,
    AFC_HIGH  = 3'b011,
    AFC_RECOV = 3'b100,
    AFC_SETTL = 3'b101
  } afc_state_e;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [11:0] sync_q;
  afc_sync #(.W(12)) u_sync
  (
    .clk   (clk),
    .reset (reset),
    .d     ({flags_pin.empty_indicator_n,
             ~flags_pin.full_indicator_n,
             ~flags_pin.cascade_out_or_half_level,
             data_out_bus_i}),
    .q     (sync_q)
  );
  // Full and half travel inverted so a cleared synchroniser reads idle
  wire       empty_n = sync_q[11];
  wire       full_n  = ~sync_q[10];
  wire       half_n  = ~sync_q[9];
  wire [8:0] rd_pin  = sync_q[8:0];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  afc_state_e     state_r, state_nxt;
  afc_cmd_e       cmd_r;
  logic [`AFC_CNT_W-1:0] cnt_r;
  logic           mode_r, lead_r, was_reset_r, refuse_r, rval_r;
  logic [8:0]     wdata_r, rdata_r, thresh_r;

  wire acc   = apb_req.psel && apb_req.penable;
  wire wr_en = acc && apb_req.pwrite;
  wire [11:0] a = apb_req.paddr;
  wire sel_ctrl = (a == `AFC_OFF_CTRL);
  wire sel_wd   = (a == `AFC_OFF_WDATA);
  wire sel_rd   = (a == `AFC_OFF_RDATA);
  wire sel_st   = (a == `AFC_OFF_STATUS);
  wire sel_th   = (a == `AFC_OFF_THRESH);
  wire mapped   = sel_ctrl | sel_wd | sel_rd | sel_st | sel_th;
  wire busy     = (state_r != AFC_IDLE);
  wire [2:0] cmd_in = apb_req.pwdata[`AFC_CMD_LSB +: `AFC_CMD_W];
  wire kick     = wr_en && sel_ctrl && !busy &&
                  (cmd_in != AFC_CMD_NONE);
  // Host-side guards keep the buffer's own blocks from mattering
  wire is_write = (afc_cmd_e'(cmd_in) == AFC_CMD_WRITE);
  wire is_read  = (afc_cmd_e'(cmd_in) == AFC_CMD_READ);
  wire is_rpl   = (afc_cmd_e'(cmd_in) == AFC_CMD_REPLAY);
  wire rst_in   = (afc_cmd_e'(cmd_in) == AFC_CMD_RESET) ||
                  (afc_cmd_e'(cmd_in) == AFC_CMD_RST_WL) ||
                  (afc_cmd_e'(cmd_in) == AFC_CMD_RST_RL);
  // Mode written with the command decides, not the one before it
  wire mode_in  = apb_req.pwdata[`AFC_CTRL_MODE_BIT];
  wire refuse   = kick && ((is_write && (!full_n || !was_reset_r))
                  || (is_read && !empty_n)
                  || (is_rpl && !mode_in));
  wire start    = kick && !refuse;
  wire is_rst   = (cmd_r == AFC_CMD_RESET) ||
                  (cmd_r == AFC_CMD_RST_WL) || (cmd_r == AFC_CMD_RST_RL);
  wire cnt_done = (cnt_r == '0);

  wire [31:0] status = {26'h0000000, refuse_r, rval_r, ~half_n,
                        ~full_n, ~empty_n, busy};
  wire [31:0] rd_mux = sel_ctrl ? {26'h0000000, lead_r, mode_r, 4'h0} :
                       sel_wd   ? {23'h000000, wdata_r} :
                       sel_rd   ? {23'h000000, rdata_r} :
                       sel_th   ? {23'h000000, thresh_r} :
                       sel_st   ? status : 32'h00000000;

  assign apb_rsp = '{pready: 1'b1, prdata: rd_mux,
                     pslverr: acc && !mapped};

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic [`AFC_CNT_W-1:0] cnt_nxt;
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!cnt_done)
      cnt_nxt = cnt_r - 1'b1;
    case (state_r)
      AFC_IDLE:
        if (start)
        begin
          state_nxt = AFC_SETUP;
          cnt_nxt   = `AFC_CNT_W'(`AFC_RSS_CYC);
        end
      AFC_SETUP:
        if (cnt_done)
        begin
          state_nxt = AFC_LOW;
          cnt_nxt   = `AFC_CNT_W'(`AFC_PULSE_CYC);
        end
      AFC_LOW:
        if (cnt_done)
        begin
          state_nxt = AFC_HIGH;
          cnt_nxt   = `AFC_CNT_W'(`AFC_PULSE_CYC);
        end
      AFC_HIGH:
        if (cnt_done)
        begin
          state_nxt = is_rst ? AFC_RECOV : AFC_SETTL;
          cnt_nxt   = is_rst ? `AFC_CNT_W'(`AFC_RSR_CYC)
                             : `AFC_CNT_W'(`AFC_REL_CYC + 2);
        end
      AFC_RECOV:
        if (cnt_done)
        begin
          state_nxt = AFC_SETTL;
          cnt_nxt   = `AFC_CNT_W'(`AFC_RSC_CYC);
        end
      AFC_SETTL:
        if (cnt_done)
          state_nxt = AFC_IDLE;
      default:
        state_nxt = AFC_IDLE;
    endcase
  end

  // Pin levels per phase; reset low spans SETUP..HIGH
  wire in_rst   = is_rst && (state_r == AFC_SETUP ||
                  state_r == AFC_LOW || state_r == AFC_HIGH);
  wire strobe   = (state_r == AFC_LOW);
  wire w_low    = strobe && ((cmd_r == AFC_CMD_WRITE) ||
                  (cmd_r == AFC_CMD_RST_WL));
  wire r_low    = strobe && ((cmd_r == AFC_CMD_READ) ||
                  (cmd_r == AFC_CMD_RST_RL));
  // Strobes stay high during replay; only the shared pin pulses
  wire rpl_low  = strobe && (cmd_r == AFC_CMD_REPLAY);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= AFC_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmd_r       <= AFC_CMD_NONE;
      mode_r      <= 1'b1;
      lead_r      <= 1'b0;
      was_reset_r <= 1'b0;
      wdata_r     <= '0;
      thresh_r    <= `AFC_THRESH_RST;
      refuse_r    <= 1'b0;
    end
    else
    begin
      if (start)
        cmd_r <= afc_cmd_e'(cmd_in);
      if (wr_en && sel_ctrl && !busy)
      begin
        mode_r <= mode_in;
        lead_r <= apb_req.pwdata[`AFC_CTRL_LEAD_BIT];
      end
      if (wr_en && sel_wd && !busy)
        wdata_r <= apb_req.pwdata[8:0];
      if (wr_en && sel_th && !busy)
        thresh_r <= apb_req.pwdata[8:0];
      if (kick)
        refuse_r <= refuse;
      if (state_r == AFC_RECOV)
        was_reset_r <= 1'b1;
    end
  end

  // Read data is taken after the synchroniser has settled
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_r <= '0;
      rval_r  <= 1'b0;
    end
    else
    begin
      if (start && is_read)
        rval_r <= 1'b0;
      if (r_low && cnt_done && (cmd_r == AFC_CMD_READ))
      begin
        rdata_r <= rd_pin;
        rval_r  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pins            <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      data_in_bus     <= '0;
      data_out_bus_o  <= '0;
      data_out_bus_oe <= 1'b0;
    end
    else
    begin
      pins.write_strobe_n <= !(state_nxt == AFC_LOW &&
        ((cmd_r == AFC_CMD_WRITE) || (cmd_r == AFC_CMD_RST_WL)));
      pins.read_strobe_n  <= !(state_nxt == AFC_LOW &&
        ((cmd_r == AFC_CMD_READ) || (cmd_r == AFC_CMD_RST_RL)));
      // In idle the command register is stale, so decode the kick itself
      pins.reset_n        <= !((state_nxt == AFC_SETUP ||
        state_nxt == AFC_LOW || state_nxt == AFC_HIGH) &&
        (state_r == AFC_IDLE ? rst_in : is_rst));
      pins.first_load_or_replay <= mode_r ?
        !(state_nxt == AFC_LOW && cmd_r == AFC_CMD_REPLAY)
        : !lead_r;
      pins.cascade_in     <= !mode_r;
      data_in_bus         <= wdata_r;
      // Threshold load through data pins while read pulses in reset
      data_out_bus_oe     <= is_rst && (cmd_r == AFC_CMD_RST_RL) &&
                             (state_r == AFC_LOW || state_r == AFC_HIGH);
      data_out_bus_o      <= thresh_r;
    end
  end

  // Data setup uses the reset phase registers; data_in_bus follows WDATA
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence rst_low_s;
    !pins.reset_n;
  endsequence

  strobe_rst_a: assert property (@(posedge clk) disable iff (reset)
    $rose(pins.reset_n) |-> pins.write_strobe_n && pins.read_strobe_n
      ##1 pins.write_strobe_n && pins.read_strobe_n)
    else $error("strobe moved around reset release");
  write_full_a: assert property (@(posedge clk) disable iff (reset)
    (kick && is_write && !full_n) |=> (state_r == AFC_IDLE))
    else $error("write started on full buffer");
  read_empty_a: assert property (@(posedge clk) disable iff (reset)
    (kick && is_read && !empty_n) |=> (state_r == AFC_IDLE))
    else $error("read started on empty buffer");
  replay_strb_a: assert property (@(posedge clk) disable iff (reset)
    rpl_low |->
      pins.write_strobe_n && pins.read_strobe_n && !pins.first_load_or_replay)
    else $error("strobe low during replay");
  strobe_w_a: assert property (@(posedge clk) disable iff (reset)
    pins.write_strobe_n == !w_low)
    else $error("write strobe outside write phase");
  rst_pin_a: assert property (@(posedge clk) disable iff (reset)
    pins.reset_n == !in_rst)
    else $error("reset pin outside reset phase");
  write_first_a: assert property (@(posedge clk) disable iff (reset)
    !was_reset_r |-> pins.write_strobe_n || !pins.reset_n)
    else $error("write before first reset");
  replay_mode_a: assert property (@(posedge clk) disable iff (reset)
    (kick && is_rpl && !mode_in) |=> refuse_r && !busy)
    else $error("replay accepted in cascade mode");
  rst_span_a: assert property (@(posedge clk) disable iff (reset)
    $fell(pins.reset_n) |-> rst_low_s [*2])
    else $error("reset pulse too short");
  cascade_pin_a: assert property (@(posedge clk) disable iff (reset)
    pins.cascade_in == !$past(mode_r))
    else $error("cascade input not following mode");
endmodule // afc_ctrl

// ==== bench/afc_fifo_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Behavioural buffer device, driven only by its pins
// ------------------------------------------------------------
// Limitation: the chain pulse of cascade operation is not modelled,
// the shared pin just idles high there.
module afc_fifo_model
  import afc_pkg::*;
#(
  parameter int DEPTH = 16384,
  parameter int UNIT  = 32
)
(
  input  wire afc_pkg::afc_pins_s pins,     // Strobes and control pins
  input  wire logic [8:0]         din,      // Write data pins
  input  wire logic [8:0]         bus,      // Resolved data pins
  output afc_pkg::afc_flags_s     flags,    // Flag pins
  output logic [8:0]              q,        // Read data
  output logic                    q_oe,     // High while driving data
  output int                      rule_err  // Controller misuse count
);
  logic [8:0] mem [DEPTH];
  int         wp       = 0;
  int         rp       = 0;
  int         cnt      = 0;
  int         thr      = DEPTH / 2;
  logic       seen_rst = 1'b0;
  logic       wr_on    = 1'b0;
  logic       rd_on    = 1'b0;

  initial
  begin
    q        = '0;
    q_oe     = 1'b0;
    rule_err = 0;
  end

  // Half level only where the cascade input is grounded
  assign flags = '{empty_indicator_n: (cnt != 0),
                   full_indicator_n: (cnt != DEPTH),
                   cascade_out_or_half_level:
                     pins.cascade_in | (cnt <= thr)};

  always @(negedge pins.reset_n)
  begin
    rp       = 0;
    wp       = 0;
    cnt      = 0;
    thr      = DEPTH / 2;
    seen_rst = 1'b1;
  end

  always @(posedge pins.reset_n)
    if (!pins.write_strobe_n || !pins.read_strobe_n)
      rule_err++;

  always @(negedge pins.write_strobe_n)
    if (!seen_rst)
      rule_err++;
    else
      wr_on = pins.reset_n && (cnt != DEPTH);

  always @(posedge pins.write_strobe_n)
    if (!pins.reset_n)
      thr = din * UNIT;
    else if (wr_on)
    begin
      mem[wp] = din;
      wp      = (wp + 1) % DEPTH;
      cnt++;
      wr_on   = 1'b0;
    end

  always @(negedge pins.read_strobe_n)
  begin
    rd_on = pins.reset_n && (cnt != 0);
    if (rd_on)
    begin
      q    = mem[rp];
      q_oe = 1'b1;
    end
  end

  always @(posedge pins.read_strobe_n)
  begin
    if (!pins.reset_n)
      thr = bus * UNIT;
    else if (rd_on)
    begin
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
    rd_on = 1'b0;
    q_oe  = 1'b0;
  end

  always @(negedge pins.first_load_or_replay)
    if (!pins.cascade_in)
    begin
      if (!pins.write_strobe_n || !pins.read_strobe_n)
        rule_err++;
      rp  = 0;
      cnt = wp;
    end
endmodule // afc_fifo_model

// ==== bench/afc_ctrl_test.sv ====
`timescale 1ns/1ps
`include "afc_cfg.svh"
module afc_ctrl_test;
  import afc_pkg::*;
  // Small depth keeps the full and wrap cases short
  localparam int DEPTH = 64;
  logic         clk;
  logic         reset;
  logic         float_v;
  afc_apb_req_s req;
  afc_apb_rsp_s rsp;
  afc_pins_s    pins;
  afc_flags_s   flags;
  logic [8:0]   din;
  logic [8:0]   bus_o;
  logic [8:0]   q;
  logic [8:0]   bus;
  logic         bus_oe;
  logic         q_oe;
  int           rule_err;
  int           errors;
  int           samples_checked;
  logic [31:0]  rd;
  logic         slverr;

  afc_ctrl uut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .pins(pins), .flags_pin(flags), .data_in_bus(din),
    .data_out_bus_i(bus), .data_out_bus_o(bus_o),
    .data_out_bus_oe(bus_oe));
  afc_fifo_model #(.DEPTH(DEPTH)) fifo (.pins(pins), .din(din),
    .bus(bus), .flags(flags), .q(q), .q_oe(q_oe), .rule_err(rule_err));

  // Released data pins wander so stale data never looks valid
  assign bus = bus_oe ? bus_o : (q_oe ? q : {9{float_v}});

  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) float_v <= ~float_v;

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      results();
    end
    rd = rsp.prdata;
    slverr = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic cmd(afc_cmd_e c, logic [31:0] mode = 32'h00000010);
    int n;
    apb(1'b1, `AFC_OFF_CTRL, mode | 32'(c));
    n = 0;
    do
    begin
      apb(1'b0, `AFC_OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[`AFC_ST_BUSY_BIT] !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      errors++;
      results();
    end
  endtask

  task automatic stat(string name, int bit_no, logic exp);
    apb(1'b0, `AFC_OFF_STATUS, 32'h0);
    chk(name, 32'(exp), 32'(rd[bit_no]));
  endtask

  task automatic put(int n, int base);
    for (int i = 0; i < n; i++)
    begin
      apb(1'b1, `AFC_OFF_WDATA, 32'((base + i) & 'h1FF));
      cmd(AFC_CMD_WRITE);
    end
  endtask

  task automatic take(int n, int base);
    for (int i = 0; i < n; i++)
    begin
      cmd(AFC_CMD_READ);
      apb(1'b0, `AFC_OFF_RDATA, 32'h0);
      chk("read word", 32'((base + i) & 'h1FF), 32'(rd[8:0]));
      chk("data drive", 32'h0, 32'(bus_oe));
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, `AFC_OFF_THRESH, 32'h0);
    chk("thresh reset", 32'(`AFC_THRESH_RST), rd);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped err", 32'h1, 32'(slverr));
    chk("unmapped data", 32'h0, rd);
    put(1, 5);
    stat("refused", `AFC_ST_REFUSE_BIT, 1'b1);
  endtask

  task automatic t_fill();
    cmd(AFC_CMD_RESET);
    stat("empty", `AFC_ST_EMPTY_BIT, 1'b1);
    stat("full", `AFC_ST_FULL_BIT, 1'b0);
    stat("half", `AFC_ST_HALF_BIT, 1'b0);
    cmd(AFC_CMD_READ);
    stat("refused", `AFC_ST_REFUSE_BIT, 1'b1);
    stat("read valid", `AFC_ST_RVAL_BIT, 1'b0);
    put(DEPTH / 2, 0);
    stat("accepted", `AFC_ST_REFUSE_BIT, 1'b0);
    stat("half", `AFC_ST_HALF_BIT, 1'b0);
    put(DEPTH / 2, DEPTH / 2);
    stat("half", `AFC_ST_HALF_BIT, 1'b1);
    stat("full", `AFC_ST_FULL_BIT, 1'b1);
    put(1, 'h1FF);
    stat("refused", `AFC_ST_REFUSE_BIT, 1'b1);
    take(1, 0);
    stat("full", `AFC_ST_FULL_BIT, 1'b0);
    take(DEPTH - 1, 1);
    stat("empty", `AFC_ST_EMPTY_BIT, 1'b1);
    put(3, 'h1A0);
    stat("empty", `AFC_ST_EMPTY_BIT, 1'b0);
    take(3, 'h1A0);
  endtask

  task automatic t_replay();
    cmd(AFC_CMD_RESET);
    put(4, 'h10);
    take(2, 'h10);
    cmd(AFC_CMD_REPLAY);
    take(4, 'h10);
    stat("empty", `AFC_ST_EMPTY_BIT, 1'b1);
    stat("read valid", `AFC_ST_RVAL_BIT, 1'b1);
  endtask

  task automatic t_thresh();
    apb(1'b1, `AFC_OFF_WDATA, 32'h0);
    cmd(AFC_CMD_RST_WL);
    put(1, 1);
    stat("half", `AFC_ST_HALF_BIT, 1'b1);
    // Offset above the fill, so a missed load would show as half set
    apb(1'b1, `AFC_OFF_THRESH, 32'h00000002);
    cmd(AFC_CMD_RST_RL);
    put(DEPTH / 2 + 2, 0);
    stat("half", `AFC_ST_HALF_BIT, 1'b0);
    cmd(AFC_CMD_RESET);
    put(DEPTH / 2 + 1, 0);
    stat("half", `AFC_ST_HALF_BIT, 1'b1);
  endtask

  task automatic t_cascade();
    cmd(AFC_CMD_RESET, 32'h00000020);
    chk("cascade pin", 32'h1, 32'(pins.cascade_in));
    chk("lead pin", 32'h0, 32'(pins.first_load_or_replay));
    cmd(AFC_CMD_REPLAY, 32'h00000020);
    stat("refused", `AFC_ST_REFUSE_BIT, 1'b1);
    cmd(AFC_CMD_RESET);
    chk("single pin", 32'h0, 32'(pins.cascade_in));
  endtask

  initial
  begin
    reset           = 1'b1;
    req             = '0;
    float_v         = 1'b0;
    errors          = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_fill();
    t_replay();
    t_thresh();
    t_cascade();
    chk("pin misuse", 32'h0, 32'(rule_err));
    results();
  end
endmodule // afc_ctrl_test
